// ### design/synth_prog_pkg.sv
package synth_prog_pkg;

  // ------------------------------------------------------------
  // serial word layout
  // ------------------------------------------------------------
  localparam int          WORD_W       = 16;
  localparam int          DATA_W       = 14;
  localparam int          ADDR_HI_BIT  = 15;
  localparam int          ADDR_LO_BIT  = 14;
  localparam logic [3:0]  LOAD_PULSES  = 4'ha;  // shift clocks after write strobe rises

  // ------------------------------------------------------------
  // destination addresses
  // ------------------------------------------------------------
  localparam logic [1:0]  ADDR_POST_SCALE = 2'h0;
  localparam logic [1:0]  ADDR_VCO_DIV    = 2'h1;
  localparam logic [1:0]  ADDR_REF_DIV    = 2'h2;
  localparam logic [1:0]  ADDR_RESERVED   = 2'h3;

  // ------------------------------------------------------------
  // values after reset
  // ------------------------------------------------------------
  localparam logic [1:0]  POST_SCALE_RST = 2'h0;
  localparam logic [13:0] VCO_DIV_RST    = 14'h0001;
  localparam logic [13:0] REF_DIV_RST    = 14'h0001;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0]
  {
    st_idle  = 2'b00,
    st_write = 2'b01,
    st_load  = 2'b10,
    st_read  = 2'b11
  } ser_state_e;

  typedef struct packed
  {
    logic sclk;
    logic wr_n;
    logic rd_n;
    logic io;
  } serial_in_s;

  typedef struct packed
  {
    logic up;
    logic dn;
  } pump_s;

  typedef struct packed
  {
    ser_state_e  state;
    logic        sclk_q;
    logic        ref_q;
    logic        vco_q;
    logic [15:0] shreg;
    logic [3:0]  load_cnt;
    logic [1:0]  post_scale_select;
    logic [13:0] vco_divide_ratio;
    logic [13:0] ref_divide_ratio;
    logic [13:0] ref_cnt;
    logic [13:0] vco_cnt;
    logic [2:0]  post_cnt;
    logic        synth;
    pump_s       pump;
    logic        io_out;
    logic        io_oe_n;
  } core_state_s;

endpackage

// ### design/synth_divider_serial_prog.sv
// What this block does
// - write strobe low: shift a sixteen-bit word in from the data pin
// - word is two address bits then fourteen data bits
// - data pin sampled at each rising shift clock during a write
// - write strobe rising: shifting stops and the word is held in the shift register
// - ten shift clocks after write strobe rises move data into the divider
// - address 00 post-scaler, 01 vco divider, 10 reference divider, 11 reserved
// - post-scaler code 00/01/10/11 divides by 1/2/4/8
// - divider values are binary ratios; zero and one both divide by one
// - read strobe low: shift register contents go out over sixteen clocks
// - each new read bit appears at the rising shift clock
// - select high: all three ratios come from fixed rom
// - reference leads: up set on reference edge, cleared on next vco edge
// - vco leads: down set on vco edge, cleared on next reference edge
// - up and down never both asserted
// - select low: ratios come from serially loaded registers
`timescale 1ns/1ps

module synth_divider_serial_prog #(
  parameter logic [13:0] ROM_REF_RATIO  = 14'h0001,
  parameter logic [13:0] ROM_VCO_RATIO  = 14'h0001,
  parameter logic [1:0]  ROM_POST_SCALE = 2'h0
) (
  input  wire logic                       i_core_clk,
  input  wire logic                       i_arst_n,
  input  wire synth_prog_pkg::serial_in_s i_serial,
  output logic                            o_io,
  output logic                            o_io_oe_n,
  input  wire logic                       i_sel,
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_vco_clk,
  output logic                            o_synth_output,
  output synth_prog_pkg::pump_s           o_pump
);

  // ------------------------------------------------------------
  // divider step
  // ------------------------------------------------------------
  // returns {terminal pulse, next count}
  function automatic logic [14:0] div_step(input logic [13:0] cnt,
                                           input logic [13:0] ratio);
    logic [13:0] last;
    last = (ratio <= 14'h0001) ? 14'h0000 : 14'(ratio - 14'h0001);
    if (cnt >= last)
    begin
      div_step = {1'b1, 14'h0000};
    end
    else
    begin
      div_step = {1'b0, 14'(cnt + 14'h0001)};
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  synth_prog_pkg::core_state_s st;
  synth_prog_pkg::core_state_s next_st;

  logic        sclk_rise;
  logic        ref_edge;
  logic        vco_edge;
  logic        ref_pulse;
  logic        vco_pulse;
  logic        commit;
  logic [13:0] ref_ratio_eff;
  logic [13:0] vco_ratio_eff;
  logic [1:0]  post_eff;
  logic [14:0] ref_step;
  logic [14:0] vco_step;

  // edges of synchronous inputs
  assign sclk_rise = i_serial.sclk & ~st.sclk_q;
  assign ref_edge  = i_ref_clk & ~st.ref_q;
  assign vco_edge  = i_vco_clk & ~st.vco_q;

  // ratio source selection
  assign ref_ratio_eff = i_sel ? ROM_REF_RATIO  : st.ref_divide_ratio;
  assign vco_ratio_eff = i_sel ? ROM_VCO_RATIO  : st.vco_divide_ratio;
  assign post_eff      = i_sel ? ROM_POST_SCALE : st.post_scale_select;

  // divided clocks
  assign ref_step  = div_step(st.ref_cnt, ref_ratio_eff);
  assign vco_step  = div_step(st.vco_cnt, vco_ratio_eff);
  assign ref_pulse = ref_edge & ref_step[14];
  assign vco_pulse = vco_edge & vco_step[14];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    next_st        = st;
    commit         = 1'b0;
    next_st.sclk_q = i_serial.sclk;
    next_st.ref_q  = i_ref_clk;
    next_st.vco_q  = i_vco_clk;
    next_st.io_oe_n = i_serial.rd_n;

    // serial port sequencing
    case (st.state)
      synth_prog_pkg::st_idle:
      begin
        if (!i_serial.wr_n)
        begin
          next_st.state = synth_prog_pkg::st_write;
          if (sclk_rise)
          begin
            next_st.shreg = {st.shreg[14:0], i_serial.io};
          end
        end
        else if (!i_serial.rd_n)
        begin
          next_st.state = synth_prog_pkg::st_read;
          if (sclk_rise)
          begin
            next_st.io_out = st.shreg[15];
            next_st.shreg  = {st.shreg[14:0], st.shreg[15]};
          end
        end
      end
      synth_prog_pkg::st_write:
      begin
        if (i_serial.wr_n)
        begin
          next_st.state    = synth_prog_pkg::st_load;
          next_st.load_cnt = 4'h0;
        end
        else if (sclk_rise)
        begin
          next_st.shreg = {st.shreg[14:0], i_serial.io};
        end
      end
      synth_prog_pkg::st_load:
      begin
        if (sclk_rise)
        begin
          if (st.load_cnt == 4'(synth_prog_pkg::LOAD_PULSES - 4'h1))
          begin
            commit        = 1'b1;
            next_st.state = synth_prog_pkg::st_idle;
          end
          else
          begin
            next_st.load_cnt = 4'(st.load_cnt + 4'h1);
          end
        end
      end
      synth_prog_pkg::st_read:
      begin
        if (i_serial.rd_n)
        begin
          next_st.state = synth_prog_pkg::st_idle;
        end
        else if (sclk_rise)
        begin
          next_st.io_out = st.shreg[15];
          next_st.shreg  = {st.shreg[14:0], st.shreg[15]};
        end
      end
      default:
      begin
        next_st.state = synth_prog_pkg::st_idle;
      end
    endcase

    // address decode of the held word
    if (commit)
    begin
      case (st.shreg[synth_prog_pkg::ADDR_HI_BIT:synth_prog_pkg::ADDR_LO_BIT])
        synth_prog_pkg::ADDR_POST_SCALE: next_st.post_scale_select = st.shreg[1:0];
        synth_prog_pkg::ADDR_VCO_DIV:    next_st.vco_divide_ratio  = st.shreg[13:0];
        synth_prog_pkg::ADDR_REF_DIV:    next_st.ref_divide_ratio  = st.shreg[13:0];
        default:                         next_st.state = synth_prog_pkg::st_idle;
      endcase
    end

    // reference and vco dividers
    if (ref_edge)
    begin
      next_st.ref_cnt = ref_step[13:0];
    end
    if (vco_edge)
    begin
      next_st.vco_cnt  = vco_step[13:0];
      next_st.post_cnt = 3'(st.post_cnt + 3'h1);
    end

    // post-scaler output
    case (post_eff)
      2'h0:    next_st.synth = i_vco_clk;
      2'h1:    next_st.synth = next_st.post_cnt[0];
      2'h2:    next_st.synth = next_st.post_cnt[1];
      default: next_st.synth = next_st.post_cnt[2];
    endcase

    // three-state phase/frequency detector
    if (ref_pulse && vco_pulse)
    begin
      next_st.pump = '0;
    end
    else if (ref_pulse)
    begin
      next_st.pump.up = ~st.pump.dn;
      next_st.pump.dn = 1'b0;
    end
    else if (vco_pulse)
    begin
      next_st.pump.dn = ~st.pump.up;
      next_st.pump.up = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st                   <= '0;
      st.state             <= synth_prog_pkg::st_idle;
      st.post_scale_select <= synth_prog_pkg::POST_SCALE_RST;
      st.vco_divide_ratio  <= synth_prog_pkg::VCO_DIV_RST;
      st.ref_divide_ratio  <= synth_prog_pkg::REF_DIV_RST;
      st.io_oe_n           <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign o_io           = st.io_out;
  assign o_io_oe_n      = st.io_oe_n;
  assign o_synth_output = st.synth;
  assign o_pump         = st.pump;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  property p_shift_in;
    (st.state == synth_prog_pkg::st_write) && !i_serial.wr_n && sclk_rise
      |=> st.shreg == {$past(st.shreg[14:0]), $past(i_serial.io)};
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("write shift wrong");

  property p_wr_to_load;
    (st.state == synth_prog_pkg::st_write) && i_serial.wr_n
      |=> (st.state == synth_prog_pkg::st_load) && (st.load_cnt == 4'h0);
  endproperty
  a_wr_to_load: assert property (p_wr_to_load) else $error("no load after write");

  property p_commit_tenth;
    commit |-> (st.load_cnt == 4'h9) && sclk_rise;
  endproperty
  a_commit_tenth: assert property (p_commit_tenth) else $error("load not on tenth clock");

  property p_vco_load;
    commit && (st.shreg[15:14] == synth_prog_pkg::ADDR_VCO_DIV)
      |=> st.vco_divide_ratio == $past(st.shreg[13:0]) && $stable(st.ref_divide_ratio);
  endproperty
  a_vco_load: assert property (p_vco_load) else $error("vco ratio not loaded");

  property p_reserved;
    commit && (st.shreg[15:14] == synth_prog_pkg::ADDR_RESERVED)
      |=> $stable(st.vco_divide_ratio) && $stable(st.ref_divide_ratio)
          && $stable(st.post_scale_select);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved write changed ratio");

  property p_read_bit;
    (st.state == synth_prog_pkg::st_read) && !i_serial.rd_n && sclk_rise
      |=> o_io == $past(st.shreg[15]);
  endproperty
  a_read_bit: assert property (p_read_bit) else $error("read bit wrong");

  property p_release;
    i_serial.rd_n |=> o_io_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("pin driven outside read");

  property p_rom;
    i_sel |-> (ref_ratio_eff == ROM_REF_RATIO) && (post_eff == ROM_POST_SCALE);
  endproperty
  a_rom: assert property (p_rom) else $error("rom ratio not used");

  property p_up_set;
    ref_pulse && !vco_pulse && !st.pump.dn |=> o_pump.up && !o_pump.dn;
  endproperty
  a_up_set: assert property (p_up_set) else $error("up not set");

  property p_dn_set;
    vco_pulse && !ref_pulse && !st.pump.up |=> o_pump.dn && !o_pump.up;
  endproperty
  a_dn_set: assert property (p_dn_set) else $error("down not set");

  property p_exclusive;
    !(o_pump.up && o_pump.dn);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("up and down together");

  c_commit: cover property (commit);
  c_read:   cover property ((st.state == synth_prog_pkg::st_read) ##1 o_io);
  c_up:     cover property (o_pump.up ##1 !o_pump.up);
  c_dn:     cover property (o_pump.dn);

endmodule

// ### bench/synth_host_model.sv
`timescale 1ns/1ps

module synth_host_model (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_io,
  input  wire logic                 i_io_oe_n,
  output synth_prog_pkg::serial_in_s o_serial
);

  logic sclk     = 1'b0;
  logic wr_n     = 1'b1;
  logic rd_n     = 1'b1;
  logic host_drv = 1'b0;
  logic host_bit = 1'b0;
  logic idle_pat = 1'b0;

  // undriven data pin shows a pattern that changes every cycle
  always @(posedge i_core_clk)
  begin
    idle_pat <= ~idle_pat;
  end

  // wire level seen by both ends of the data pin
  assign o_serial = {sclk, wr_n, rd_n,
                     (!i_io_oe_n) ? i_io : (host_drv ? host_bit : idle_pat)};

  // one shift clock period: data set while low, then four cycles high
  task automatic pulse(input logic bit_val);
    host_bit <= bit_val;
    repeat (4) @(posedge i_core_clk);
    sclk <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    sclk <= 1'b0;
  endtask

  // shift clocks with both strobes high
  task automatic idle_clocks(input int n);
    repeat (n) pulse(1'b0);
  endtask

  // write one word, address first, then the load clocks
  task automatic write_word(input logic [15:0] w);
    wr_n     <= 1'b0;
    host_drv <= 1'b1;
    for (int i = 15; i >= 0; i--)
    begin
      pulse(w[i]);
    end
    repeat (4) @(posedge i_core_clk);
    wr_n     <= 1'b1;
    host_drv <= 1'b0;
    idle_clocks(10);
  endtask

  // read sixteen bits, sampled late in each high phase
  task automatic read_word(output logic [15:0] w);
    rd_n <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    for (int i = 15; i >= 0; i--)
    begin
      sclk <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      w[i] = o_serial.io;
      @(posedge i_core_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge i_core_clk);
    end
    rd_n <= 1'b1;
    idle_clocks(10);
  endtask

endmodule

// ### bench/synth_divider_serial_prog_tb.sv
`timescale 1ns/1ps

module synth_divider_serial_prog_tb;

  logic                       i_core_clk = 1'b0;
  logic                       i_arst_n   = 1'b0;
  logic                       i_sel      = 1'b0;
  logic                       i_ref_clk  = 1'b0;
  logic                       i_vco_clk  = 1'b0;
  logic [1:0]                 div_cnt    = 2'h0;
  logic                       o_io;
  logic                       o_io_oe_n;
  logic                       o_synth_output;
  synth_prog_pkg::pump_s      o_pump;
  synth_prog_pkg::serial_in_s serial;
  int                         n_errors   = 0;
  int                         compares   = 0;
  int                         cycles     = 0;

  // ------------------------------------------------------------
  // clocks, design and host
  // ------------------------------------------------------------
  always #2.5 i_core_clk = ~i_core_clk;

  // reference and vco share one phase, period eight core clocks
  always @(posedge i_core_clk)
  begin
    div_cnt <= div_cnt + 2'h1;
    if (div_cnt == 2'h3)
    begin
      i_ref_clk <= ~i_ref_clk;
      i_vco_clk <= ~i_vco_clk;
    end
  end

  synth_divider_serial_prog dut_u (
    .i_core_clk     (i_core_clk),
    .i_arst_n       (i_arst_n),
    .i_serial       (serial),
    .o_io           (o_io),
    .o_io_oe_n      (o_io_oe_n),
    .i_sel          (i_sel),
    .i_ref_clk      (i_ref_clk),
    .i_vco_clk      (i_vco_clk),
    .o_synth_output (o_synth_output),
    .o_pump         (o_pump)
  );

  synth_host_model host_u (
    .i_core_clk (i_core_clk),
    .i_io       (o_io),
    .i_io_oe_n  (o_io_oe_n),
    .o_serial   (serial)
  );

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // hang guard
  always @(posedge i_core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      n_errors++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  // written word comes back msb first, pin released around the read
  task automatic test_read_back();
    logic [15:0] w;
    check(o_io_oe_n, 1'b1, "pin driven while idle");
    host_u.write_word({synth_prog_pkg::ADDR_VCO_DIV, 14'h2a5b});
    host_u.read_word(w);
    check(w, {synth_prog_pkg::ADDR_VCO_DIV, 14'h2a5b}, "read back word");
    check(o_io_oe_n, 1'b1, "pin driven after read");
  endtask

  // cycles between the first two rising edges of the synthesized output
  task automatic synth_period(output int p);
    logic prev;
    int   first;
    prev = 1'b1;
    first = -1;
    p = 0;
    for (int c = 0; c < 400; c++)
    begin
      @(posedge i_core_clk);
      if (o_synth_output === 1'b1 && prev === 1'b0 && p == 0)
        p = (first >= 0) ? c - first : 0;
      if (o_synth_output === 1'b1 && prev === 1'b0 && first < 0)
        first = c;
      prev = o_synth_output;
    end
  endtask

  // output period for each post-scaler code
  task automatic test_post_scale();
    int p;
    for (int k = 0; k < 4; k++)
    begin
      host_u.write_word({synth_prog_pkg::ADDR_POST_SCALE, 12'h000, k[1:0]});
      synth_period(p);
      check(p, 8 << k, "output period");
    end
  endtask

  // reset in mid-run: outputs go idle, ratios and post code return to reset values
  task automatic test_reset();
    int p;
    i_arst_n <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    check(o_pump, 2'h0, "pump active during reset");
    check(o_io_oe_n, 1'b1, "pin driven during reset");
    check(o_synth_output, 1'b0, "output high during reset");
    i_arst_n <= 1'b1;
    @(posedge i_core_clk);
    pump_window(1'b0, 1'b0, "ratios after reset");
    synth_period(p);
    check(p, 8 << synth_prog_pkg::POST_SCALE_RST, "post code after reset");
  endtask

  // watch the detector for a while and judge who leads
  task automatic pump_window(input logic exp_up, input logic exp_dn, input string msg);
    int up_n;
    int dn_n;
    int both_n;
    up_n = 0;
    dn_n = 0;
    both_n = 0;
    // let the detector settle after a ratio or source change
    repeat (16) @(posedge i_core_clk);
    repeat (400)
    begin
      @(posedge i_core_clk);
      up_n += (o_pump.up === 1'b1);
      dn_n += (o_pump.dn === 1'b1);
      both_n += (o_pump.up === 1'b1 && o_pump.dn === 1'b1);
    end
    check(up_n != 0, exp_up, msg);
    check(dn_n != 0, exp_dn, msg);
    check(both_n, 0, "up and down together");
  endtask

  // ratios set leader; reserved writes and rom select
  task automatic test_pump();
    host_u.write_word({synth_prog_pkg::ADDR_VCO_DIV, 14'h0002});
    host_u.write_word({synth_prog_pkg::ADDR_REF_DIV, 14'h0001});
    pump_window(1'b1, 1'b0, "reference leads");
    host_u.write_word({synth_prog_pkg::ADDR_RESERVED, 14'h0001});
    pump_window(1'b1, 1'b0, "after reserved write");
    host_u.write_word({synth_prog_pkg::ADDR_VCO_DIV, 14'h0000});
    host_u.write_word({synth_prog_pkg::ADDR_REF_DIV, 14'h0002});
    pump_window(1'b0, 1'b1, "vco leads");
    i_sel <= 1'b1;
    pump_window(1'b0, 1'b0, "rom ratios");
    i_sel <= 1'b0;
    pump_window(1'b0, 1'b1, "registers again");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    @(posedge i_core_clk);
    host_u.idle_clocks(10);
    test_read_back();
    test_post_scale();
    test_pump();
    test_reset();
    finish_test();
  end

endmodule
